/* File: core/sgh_pkg.sv */
// Purpose : Shared constants for the management interrupt group and hang timer
// Assumes : 250 MHz core clock, 8-bit register port
// Notes   : Configuration offsets are indices within logical unit eight; runtime offsets need no unit
package sgh_pkg;

   // -----------------------------------------------------------------
   // Register addressing
   // -----------------------------------------------------------------
   localparam logic [7:0] UNIT_EIGHT     = 8'h08;
   localparam logic [7:0] IDX_HANG_COUNT = 8'hB0;
   localparam logic [7:0] IDX_EN_FIRST   = 8'hB4;
   localparam logic [7:0] IDX_EN_SECOND  = 8'hB5;
   localparam logic [7:0] IDX_ST_FIRST   = 8'hB6;
   localparam logic [7:0] IDX_ST_SECOND  = 8'hB7;
   localparam logic [7:0] IDX_PIN15_CFG  = 8'hE5;
   localparam logic [7:0] IDX_WD_CTRL    = 8'hF4;
   // Runtime index/data map
   localparam logic [7:0] RT_HANG_COUNT  = 8'h08;
   localparam logic [7:0] RT_EN_FIRST    = 8'h0C;
   localparam logic [7:0] RT_EN_SECOND   = 8'h0D;
   localparam logic [7:0] RT_ST_FIRST    = 8'h0E;
   localparam logic [7:0] RT_ST_SECOND   = 8'h0F;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int NUM_SRC          = 10;
   localparam int FIRST_SRC_BITS   = 7;   // Sources 0..6 live in the first pair
   localparam int BIT_KBC_ROUTE    = 3;   // Second enable register
   localparam int BIT_PIN_ENABLE   = 7;   // Second enable register
   localparam int BIT_HANG_ENABLE  = 4;   // Watchdog control
   localparam int BIT_PIN15_INPUT  = 0;   // Pin fifteen config: 1 = input
   localparam int BIT_PIN15_ALOW   = 1;   // Pin fifteen config: active low
   localparam int BIT_PIN15_ALT    = 2;   // Pin fifteen config: hang pulse select

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_HANG_COUNT = 8'h00;
   localparam logic [7:0] RST_EN         = 8'h00;
   localparam logic [7:0] RST_PIN15_CFG  = 8'h01;
   localparam logic [7:0] RST_WD_CTRL    = 8'h00;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ       = 250;
   localparam int TICK_TIME_US  = 1000;  // One count of the hang timer
   localparam int TICK_CYCLES   = TICK_TIME_US * CLK_MHZ;
   localparam int PULSE_TIME_US = 1000;  // Expiry pulse, within 1 ms .. 250 ms
   localparam int PULSE_CYCLES  = PULSE_TIME_US * CLK_MHZ;
   localparam int TIMER_W       = 18;

   typedef enum logic [1:0] {HT_IDLE, HT_RUN, HT_PULSE, HT_DONE} sgh_hang_state_t;

endpackage

/* File: core/sgh_hang_timer.sv */
// Purpose : Hang timer, counts down after a management interrupt and pulses
// Assumes : Loads only arrive while the enable is low
// Notes   : Once expired the count holds zero until reset
`timescale 1ns/1ps
module sgh_hang_timer
   import sgh_pkg::*;
#(
   parameter int TICKS  = TICK_CYCLES,
   parameter int PULSES = PULSE_CYCLES
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       enable,
   input  wire logic       start,
   input  wire logic       load,
   input  wire logic [7:0] load_value,
   output logic      [7:0] count_q,
   output logic            pulse_q,
   output logic            running_q
);

   sgh_hang_state_t       state_q, state_d;
   logic [7:0]            count_d;
   logic [TIMER_W-1:0]    tick_q, tick_d;
   logic                  pulse_d;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      tick_d  = tick_q;
      pulse_d = pulse_q;
      unique case (state_q)
         HT_IDLE:
         begin
            if (load)
            begin
               count_d = load_value;
            end
            else if (enable && start && count_q != 8'h00)
            begin
               state_d = HT_RUN;
               tick_d  = '0;
            end
         end
         HT_RUN:
         begin
            if (!enable)
            begin
               // Stop; a following write reloads
               state_d = HT_IDLE;
               if (load)
               begin
                  count_d = load_value;
               end
            end
            else if (tick_q == TIMER_W'(TICKS - 1))
            begin
               tick_d  = '0;
               count_d = count_q - 8'h01;
               if (count_q == 8'h01)
               begin
                  state_d = HT_PULSE;
                  pulse_d = 1'b1;
               end
            end
            else
            begin
               tick_d = tick_q + TIMER_W'(1);
            end
         end
         HT_PULSE:
         begin
            // Pulse width is fixed, enable cannot cut it short
            if (tick_q == TIMER_W'(PULSES - 1))
            begin
               state_d = HT_DONE;
               pulse_d = 1'b0;
            end
            else
            begin
               tick_d = tick_q + TIMER_W'(1);
            end
         end
         HT_DONE:
         begin
            count_d = 8'h00;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state_q   <= HT_IDLE;
         count_q   <= RST_HANG_COUNT;
         tick_q    <= '0;
         pulse_q   <= 1'b0;
         running_q <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         count_q   <= count_d;
         tick_q    <= tick_d;
         pulse_q   <= pulse_d;
         running_q <= (state_d == HT_RUN);
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_expire;
      state_q == HT_RUN && enable && count_q == 8'h01 && tick_q == TIMER_W'(TICKS - 1);
   endsequence

   chk_run_start: assert property (state_q == HT_IDLE && !load && enable && start
      && count_q != 8'h00 |=> state_q == HT_RUN)
      else $error("hang timer did not start");
   chk_expiry_pulse: assert property (s_expire |=> pulse_q && count_q == 8'h00)
      else $error("expiry did not raise pulse");
   chk_pulse_width: assert property ($fell(pulse_q) |-> $past(tick_q)
      == TIMER_W'(PULSES - 1) && state_q == HT_DONE)
      else $error("pulse ended at wrong width");
   chk_done_hold: assert property (state_q == HT_DONE |=> state_q == HT_DONE
      && count_q == 8'h00 && !pulse_q)
      else $error("expired count left zero");
   chk_disable_stop: assert property (state_q == HT_RUN && !enable |=> state_q == HT_IDLE
      && count_q == ($past(load) ? $past(load_value) : $past(count_q)))
      else $error("disable did not stop timer");

endmodule

/* File: core/sgh_mgmt_irq.sv */
// Purpose : Management interrupt group with hang timer and pin fifteen output
// Assumes : Register port strobes are single-cycle and synchronous
// Notes   : Read data appear one cycle after the read strobe
// Functional notes
// - The group interrupt is the OR of each of ten source requests ANDed with its enable.
// - The group interrupt reaches its pin only while bit 7 of the second enable is set.
// - The second enable register also routes the keyboard port bit onto the group.
// - Each status bit sets on its event whether or not the source is enabled.
// - The enables and statuses sit at B4-B7 in unit eight and on the runtime pair.
// - Asserting the management interrupt starts the hang timer when it is enabled and its count is not zero.
// - Expiry of the hang timer gives a 1 ms to 250 ms pulse on pin fifteen.
// - Bit 4 of watchdog control at F4 enables the hang timer, off by default.
// - The hang count sits at B0 of unit eight and at runtime index 08.
// - Pin fifteen can be active high, active low or an input, and resets as input.
// - After expiry the count holds zero until reset.
// - Count reads are live; software reads until two reads agree.
// - Reset clears the hang count and its enable.
// - The hang pulse reaches pin fifteen only when its configuration selects it.
`timescale 1ns/1ps
module sgh_mgmt_irq
   import sgh_pkg::*;
#(
   parameter int TICKS  = TICK_CYCLES,
   parameter int PULSES = PULSE_CYCLES
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       cfg_mode,
   input  wire logic [7:0] reg_unit,
   input  wire logic [7:0] reg_index,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_q,
   input  wire logic       req_parallel_src,
   input  wire logic       req_serial_two_src,
   input  wire logic       req_serial_one_src,
   input  wire logic       req_floppy_src,
   input  wire logic       req_gpio_group_two,
   input  wire logic       req_gpio_group_one,
   input  wire logic       req_watchdog_src,
   input  wire logic       req_mouse_src,
   input  wire logic       req_keyboard_src,
   input  wire logic       req_infrared_src,
   input  wire logic       kbc_port_bit_twelve,
   output logic            mgmt_irq_n_q,
   output logic            general_pin_fifteen_out_q,
   output logic            general_pin_fifteen_oe_q
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [NUM_SRC-1:0] req_vec;
   logic [NUM_SRC-1:0] en_vec;
   logic [NUM_SRC-1:0] status_q, status_d, status_clr;
   logic [7:0]         en1_q, en1_d, en2_q, en2_d;
   logic [7:0]         pin_cfg_q, pin_cfg_d, wd_ctrl_q, wd_ctrl_d;
   logic [7:0]         rdata_d;
   logic               irq_n_d, pin_out_d, pin_oe_d;
   logic               group_irq;
   logic               hit_count, hit_en1, hit_en2, hit_st1, hit_st2, hit_pin, hit_wd;
   logic [7:0]         hang_count;
   logic               hang_pulse;
   logic               hang_running;

   // Source order matches the enable and status bit order
   assign req_vec = {req_infrared_src, req_keyboard_src, req_mouse_src,
                     req_watchdog_src, req_gpio_group_one, req_gpio_group_two,
                     req_floppy_src, req_serial_one_src, req_serial_two_src,
                     req_parallel_src};
   assign en_vec  = {en2_q[NUM_SRC-FIRST_SRC_BITS-1:0], en1_q[FIRST_SRC_BITS-1:0]};

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // Config mode needs unit eight; runtime pair needs no unit
   always_comb
   begin
      hit_count = cfg_mode ? (reg_unit == UNIT_EIGHT && reg_index == IDX_HANG_COUNT)
                           : (reg_index == RT_HANG_COUNT);
      hit_en1   = cfg_mode ? (reg_unit == UNIT_EIGHT && reg_index == IDX_EN_FIRST)
                           : (reg_index == RT_EN_FIRST);
      hit_en2   = cfg_mode ? (reg_unit == UNIT_EIGHT && reg_index == IDX_EN_SECOND)
                           : (reg_index == RT_EN_SECOND);
      hit_st1   = cfg_mode ? (reg_unit == UNIT_EIGHT && reg_index == IDX_ST_FIRST)
                           : (reg_index == RT_ST_FIRST);
      hit_st2   = cfg_mode ? (reg_unit == UNIT_EIGHT && reg_index == IDX_ST_SECOND)
                           : (reg_index == RT_ST_SECOND);
      hit_pin   = cfg_mode && reg_unit == UNIT_EIGHT && reg_index == IDX_PIN15_CFG;
      hit_wd    = cfg_mode && reg_unit == UNIT_EIGHT && reg_index == IDX_WD_CTRL;
   end

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   always_comb
   begin
      en1_d     = (reg_wr_en && hit_en1) ? reg_wdata : en1_q;
      en2_d     = (reg_wr_en && hit_en2) ? reg_wdata : en2_q;
      pin_cfg_d = (reg_wr_en && hit_pin) ? reg_wdata : pin_cfg_q;
      wd_ctrl_d = (reg_wr_en && hit_wd)  ? reg_wdata : wd_ctrl_q;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         en1_q     <= RST_EN;
         en2_q     <= RST_EN;
         pin_cfg_q <= RST_PIN15_CFG;
         wd_ctrl_q <= RST_WD_CTRL;
      end
      else
      begin
         en1_q     <= en1_d;
         en2_q     <= en2_d;
         pin_cfg_q <= pin_cfg_d;
         wd_ctrl_q <= wd_ctrl_d;
      end
   end

   // -----------------------------------------------------------------
   // Status, write one to clear
   // -----------------------------------------------------------------
   // A request in the clearing cycle keeps its bit set
   always_comb
   begin
      status_clr = '0;
      if (reg_wr_en && hit_st1)
      begin
         status_clr[FIRST_SRC_BITS-1:0] = reg_wdata[FIRST_SRC_BITS-1:0];
      end
      if (reg_wr_en && hit_st2)
      begin
         status_clr[NUM_SRC-1:FIRST_SRC_BITS] = reg_wdata[NUM_SRC-FIRST_SRC_BITS-1:0];
      end
      status_d = (status_q & ~status_clr) | req_vec;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         status_q <= '0;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   // -----------------------------------------------------------------
   // Group interrupt and pins
   // -----------------------------------------------------------------
   always_comb
   begin
      group_irq = (|(req_vec & en_vec))
                  | (en2_q[BIT_KBC_ROUTE] & kbc_port_bit_twelve);
      irq_n_d   = ~(en2_q[BIT_PIN_ENABLE] & group_irq);
      // Input setting suppresses the pulse entirely
      pin_oe_d  = ~pin_cfg_q[BIT_PIN15_INPUT] & pin_cfg_q[BIT_PIN15_ALT];
      pin_out_d = hang_pulse ^ pin_cfg_q[BIT_PIN15_ALOW];
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         mgmt_irq_n_q              <= 1'b1;
         general_pin_fifteen_out_q <= 1'b0;
         general_pin_fifteen_oe_q  <= 1'b0;
      end
      else
      begin
         mgmt_irq_n_q              <= irq_n_d;
         general_pin_fifteen_out_q <= pin_out_d;
         general_pin_fifteen_oe_q  <= pin_oe_d;
      end
   end

   // -----------------------------------------------------------------
   // Hang timer
   // -----------------------------------------------------------------
   // Started by the interrupt as driven on the pin
   sgh_hang_timer #(
      .TICKS  (TICKS),
      .PULSES (PULSES)
   ) u_hang (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .enable     (wd_ctrl_q[BIT_HANG_ENABLE]),
      .start      (~mgmt_irq_n_q),
      .load       (reg_wr_en && hit_count),
      .load_value (reg_wdata),
      .count_q    (hang_count),
      .pulse_q    (hang_pulse),
      .running_q  (hang_running)
   );

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_rd_en)
      begin
         rdata_d = 8'h00;
         if (hit_count)
         begin
            rdata_d = hang_count;
         end
         if (hit_en1)
         begin
            rdata_d = en1_q;
         end
         if (hit_en2)
         begin
            rdata_d = en2_q;
         end
         if (hit_st1)
         begin
            rdata_d = {1'b0, status_q[FIRST_SRC_BITS-1:0]};
         end
         if (hit_st2)
         begin
            rdata_d = {5'h00, status_q[NUM_SRC-1:FIRST_SRC_BITS]};
         end
         if (hit_pin)
         begin
            rdata_d = pin_cfg_q;
         end
         if (hit_wd)
         begin
            rdata_d = wd_ctrl_q;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         reg_rdata_q <= 8'h00;
      end
      else
      begin
         reg_rdata_q <= rdata_d;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // Enabled hits rebuilt here, apart from the pin path
   logic [NUM_SRC-1:0] src_hits;
   assign src_hits = req_vec & en_vec;

   chk_group_or: assert property (##1 mgmt_irq_n_q == !($past(en2_q[BIT_PIN_ENABLE])
      && ($past(src_hits) != '0 || ($past(en2_q[BIT_KBC_ROUTE])
      && $past(kbc_port_bit_twelve)))))
      else $error("group interrupt mismatch");

   chk_pin_gate: assert property (!en2_q[BIT_PIN_ENABLE] |=> mgmt_irq_n_q)
      else $error("interrupt pin not gated");

   chk_kbc_route: assert property (!en2_q[BIT_KBC_ROUTE] && src_hits == '0
      |=> mgmt_irq_n_q)
      else $error("port bit not gated");

   chk_status_set: assert property (req_vec != '0 |=> (status_q & $past(req_vec))
      == $past(req_vec))
      else $error("status bit not set");

   chk_unit_gate: assert property (reg_wr_en && cfg_mode && reg_unit != UNIT_EIGHT
      |=> $stable(en1_q) && $stable(wd_ctrl_q))
      else $error("write hit other unit");

   chk_count_read: assert property (reg_rd_en && hit_count |=> reg_rdata_q
      == $past(hang_count))
      else $error("count read not live");

   chk_pin_input: assert property (pin_cfg_q[BIT_PIN15_INPUT] |=> !general_pin_fifteen_oe_q)
      else $error("input pin driven");

   chk_pin_select: assert property (!pin_cfg_q[BIT_PIN15_ALT]
      |=> !general_pin_fifteen_oe_q)
      else $error("unselected pin driven");

   chk_pulse_level: assert property (hang_pulse
      |=> general_pin_fifteen_out_q != $past(pin_cfg_q[BIT_PIN15_ALOW]))
      else $error("pulse level wrong");

   chk_hang_off: assert property (!wd_ctrl_q[BIT_HANG_ENABLE] |=> !hang_running)
      else $error("hang timer ran while disabled");

endmodule

/* File: tb/sgh_host_model.sv */
// Purpose : Host side of the block, power gate watching pin fifteen
// Assumes : Undriven pin fifteen is pulled to its inactive level
// Notes   : Measures hang pulse widths in core clocks
`timescale 1ns/1ps
module sgh_host_model (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic active_low,
   output logic      pin_level,
   output int        pulse_count,
   output int        pulse_len
);
   int run;

   // -----------------------------------------------------------------
   // Wire level and pulse measurement
   // -----------------------------------------------------------------
   // Pull keeps a released line inactive, so an input pin never gates power
   assign pin_level = pin_oe ? pin_out : active_low;

   // Count active cycles, latch the width when the pulse ends
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         run <= 0;
         pulse_count <= 0;
         pulse_len <= 0;
      end
      else if (pin_level != active_low)
         run <= run + 1;
      else if (run != 0)
      begin
         pulse_len <= run;
         pulse_count <= pulse_count + 1;
         run <= 0;
      end
   end
endmodule

/* File: tb/sgh_mgmt_irq_test.sv */
// Purpose : Self-checking bench for the management interrupt group
// Assumes : Shortened hang timer counts, register port on config and runtime map
// Notes   : Row table for source cases, hand tests for timer and reset
`timescale 1ns/1ps
module sgh_mgmt_irq_test
   import sgh_pkg::*;
();
   localparam int TK = 4;
   localparam int PL = 3;
   typedef struct packed {
      logic [10:0] req;
      logic [7:0]  en1;
      logic [7:0]  en2;
      logic        irq_n;
      logic [7:0]  st1;
      logic [7:0]  st2;
   } sgh_row_t;

   logic        core_clk  = 1'b0;
   logic        rst_b     = 1'b0;
   logic        cfg_mode  = 1'b1;
   logic [7:0]  reg_unit  = UNIT_EIGHT;
   logic [7:0]  reg_index = 8'h00;
   logic        reg_wr_en = 1'b0;
   logic        reg_rd_en = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [10:0] req_v     = 11'h000;
   logic        alow      = 1'b0;
   logic [7:0]  reg_rdata_q;
   logic        mgmt_irq_n_q;
   logic        pin_out;
   logic        pin_oe;
   logic        pin_level;
   int          pulse_count;
   int          pulse_len;
   int          n_fail    = 0;
   int          n_tests   = 0;

   // -----------------------------------------------------------------
   // Clock, design and host model
   // -----------------------------------------------------------------
   // 250 MHz core clock
   always #2 core_clk = ~core_clk;

   sgh_mgmt_irq #(.TICKS(TK), .PULSES(PL)) sgh_mgmt_irq_inst (
      .core_clk(core_clk), .rst_b(rst_b), .cfg_mode(cfg_mode), .reg_unit(reg_unit),
      .reg_index(reg_index), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .req_parallel_src(req_v[0]), .req_serial_two_src(req_v[1]),
      .req_serial_one_src(req_v[2]), .req_floppy_src(req_v[3]),
      .req_gpio_group_two(req_v[4]), .req_gpio_group_one(req_v[5]),
      .req_watchdog_src(req_v[6]), .req_mouse_src(req_v[7]),
      .req_keyboard_src(req_v[8]), .req_infrared_src(req_v[9]),
      .kbc_port_bit_twelve(req_v[10]), .mgmt_irq_n_q(mgmt_irq_n_q),
      .general_pin_fifteen_out_q(pin_out), .general_pin_fifteen_oe_q(pin_oe));

   sgh_host_model sgh_host_model_inst (
      .core_clk(core_clk), .rst_b(rst_b), .pin_out(pin_out), .pin_oe(pin_oe),
      .active_low(alow), .pin_level(pin_level), .pulse_count(pulse_count),
      .pulse_len(pulse_len));

   // -----------------------------------------------------------------
   // Bench tasks
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Strobe drops one edge before the next access, never re-raised in one step
   task automatic wr(input logic m, input logic [7:0] idx, input logic [7:0] d);
      cfg_mode = m;
      reg_index = idx;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      cyc(1);
      reg_wr_en = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic m, input logic [7:0] idx, output logic [7:0] d);
      cfg_mode = m;
      reg_index = idx;
      reg_rd_en = 1'b1;
      cyc(1);
      reg_rd_en = 1'b0;
      d = reg_rdata_q;
      cyc(1);
   endtask

   // Reset state of every register, two unmapped places and the pins
   task automatic reset_vals;
      logic [7:0]  v;
      logic [16:0] tab [9];
      tab = '{{1'b1, IDX_HANG_COUNT, RST_HANG_COUNT}, {1'b1, IDX_EN_FIRST, RST_EN},
              {1'b1, IDX_EN_SECOND, RST_EN}, {1'b1, IDX_ST_FIRST, 8'h00},
              {1'b1, IDX_ST_SECOND, 8'h00}, {1'b1, IDX_PIN15_CFG, RST_PIN15_CFG},
              {1'b1, IDX_WD_CTRL, RST_WD_CTRL}, {1'b1, 8'hB1, 8'h00},
              {1'b0, IDX_PIN15_CFG, 8'h00}};
      for (int i = 0; i < 9; i++)
      begin
         rd(tab[i][16], tab[i][15:8], v);
         check("reset value", v, tab[i][7:0]);
      end
      check("irq idle", {7'h00, mgmt_irq_n_q}, 8'h01);
      check("pin idle", {6'h00, pin_oe, pin_out}, 8'h00);
      $display("test reset values done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      n_fail++;
      $display("BAD run time expected done seen hang");
      end_of_test;
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      logic [7:0] v;
      logic [7:0] w;
      logic       m;
      int         t;
      sgh_row_t   rows [14];
      // One enabled source per row, then pin gate, mask and port route cases
      for (int i = 0; i < 10; i++)
      begin
         rows[i].req = 11'(1 << i);
         rows[i].st1 = (i < FIRST_SRC_BITS) ? 8'(1 << i) : 8'h00;
         rows[i].st2 = (i < FIRST_SRC_BITS) ? 8'h00 : 8'(1 << (i - FIRST_SRC_BITS));
         rows[i].en1 = rows[i].st1;
         rows[i].en2 = rows[i].st2 | 8'h80;
         rows[i].irq_n = 1'b0;
      end
      rows[10] = '{11'h008, 8'h08, 8'h00, 1'b1, 8'h08, 8'h00};
      rows[11] = '{11'h080, 8'h7F, 8'h86, 1'b1, 8'h00, 8'h01};
      rows[12] = '{11'h400, 8'h00, 8'h88, 1'b0, 8'h00, 8'h00};
      rows[13] = '{11'h400, 8'h00, 8'h80, 1'b1, 8'h00, 8'h00};
      cyc(16);
      rst_b = 1'b1;
      cyc(1);
      wr(1'b1, 8'hB1, 8'h5A);
      // Write aimed at another unit, checked as still reset below
      reg_unit = 8'h07;
      wr(1'b1, IDX_EN_FIRST, 8'h7F);
      reg_unit = UNIT_EIGHT;
      reset_vals();
      for (int r = 0; r < 14; r++)
      begin
         m = (r % 2 == 0);
         wr(m, m ? IDX_EN_FIRST : RT_EN_FIRST, rows[r].en1);
         wr(m, m ? IDX_EN_SECOND : RT_EN_SECOND, rows[r].en2);
         req_v = rows[r].req;
         cyc(2);
         check("irq pin", {7'h00, mgmt_irq_n_q}, {7'h00, rows[r].irq_n});
         rd(m, m ? IDX_EN_SECOND : RT_EN_SECOND, v);
         check("enable two", v, rows[r].en2);
         if (!rows[r].req[10])
         begin
            rd(m, m ? IDX_ST_FIRST : RT_ST_FIRST, v);
            check("status one", v, rows[r].st1);
            rd(m, m ? IDX_ST_SECOND : RT_ST_SECOND, v);
            check("status two", v, rows[r].st2);
         end
         req_v = 11'h000;
         wr(m, m ? IDX_ST_FIRST : RT_ST_FIRST, 8'hFF);
         wr(m, m ? IDX_ST_SECOND : RT_ST_SECOND, 8'hFF);
         $display("test row %0d done", r);
      end
      // Hang timer: disable, load, arm, then raise the floppy source
      wr(1'b1, IDX_PIN15_CFG, 8'h04);
      check("pin drive", {6'h00, pin_oe, pin_out}, 8'h02);
      wr(1'b1, IDX_WD_CTRL, 8'h00);
      wr(1'b0, RT_HANG_COUNT, 8'h02);
      rd(1'b1, IDX_HANG_COUNT, v);
      check("count load", v, 8'h02);
      wr(1'b1, IDX_EN_FIRST, 8'h08);
      wr(1'b1, IDX_EN_SECOND, 8'h80);
      wr(1'b1, IDX_WD_CTRL, 8'h10);
      req_v = 11'h008;
      t = 0;
      fork
         while (pin_level === alow && t < 60)
         begin
            cyc(1);
            t++;
         end
         begin
            // One tick into the run the count has already moved
            cyc(TK + 2);
            rd(1'b0, RT_HANG_COUNT, v);
         end
      join
      check("live count", v, 8'h01);
      check("expiry time", 8'(t >= 2 * TK && t <= 2 * TK + 4), 8'h01);
      cyc(PL + 3);
      check("pulse count", 8'(pulse_count), 8'h01);
      check("pulse width", 8'(pulse_len), 8'(PL));
      rd(1'b1, IDX_HANG_COUNT, v);
      check("expired count", v, 8'h00);
      rd(1'b1, IDX_WD_CTRL, v);
      check("enable kept", v, 8'h10);
      wr(1'b1, IDX_WD_CTRL, 8'h00);
      wr(1'b1, IDX_HANG_COUNT, 8'h05);
      rd(1'b1, IDX_HANG_COUNT, v);
      check("count held", v, 8'h00);
      req_v = 11'h000;
      $display("test hang expiry done");
      // Reset after expiry clears the expired state
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc(1);
      reset_vals();
      // Stop by clearing the enable, then reload, active low pin
      alow = 1'b1;
      wr(1'b1, IDX_PIN15_CFG, 8'h06);
      check("low idle", {6'h00, pin_oe, pin_out}, 8'h03);
      wr(1'b1, IDX_EN_FIRST, 8'h08);
      wr(1'b1, IDX_EN_SECOND, 8'h80);
      wr(1'b1, IDX_HANG_COUNT, 8'h03);
      wr(1'b1, IDX_WD_CTRL, 8'h10);
      req_v = 11'h008;
      cyc(6);
      wr(1'b1, IDX_WD_CTRL, 8'h00);
      req_v = 11'h000;
      rd(1'b1, IDX_HANG_COUNT, v);
      cyc(2 * TK);
      rd(1'b1, IDX_HANG_COUNT, w);
      check("stopped count", w, v);
      check("count moved", v, 8'h02);
      wr(1'b1, IDX_HANG_COUNT, 8'h04);
      rd(1'b1, IDX_HANG_COUNT, v);
      check("reload", v, 8'h04);
      check("no pulse", 8'(pulse_count), 8'h00);
      wr(1'b1, IDX_PIN15_CFG, 8'h02);
      check("unselected", {7'h00, pin_oe}, 8'h00);
      wr(1'b1, IDX_PIN15_CFG, 8'h07);
      check("input pin", {7'h00, pin_oe}, 8'h00);
      $display("test hang stop done");
      end_of_test();
   end
endmodule
